// *** common/eeprom_port_consts.svh ***
`ifndef EEPROM_PORT_CONSTS_SVH
`define EEPROM_PORT_CONSTS_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define BUS_CONTROL_ADDR   8'h90
`define CLOCK_BIT_POS      2
`define DATA_BIT_POS       1
`define POWER_BIT_POS      0
`define BUS_CONTROL_RESET  3'h7
`define EEPROM_BYTES       128
`define FIFO_DEPTH         4
`endif

// *** common/eeprom_port_pkg.sv ***
`default_nettype none
package eeprom_port_pkg;
   typedef enum logic [1:0] {
      bus_idle,
      bus_busy
   } bus_state_type;
endpackage
`default_nettype wire

// *** logic/event_fifo.sv ***
`default_nettype none
module event_fifo #(
   parameter int WIDTH = 2,
   parameter int DEPTH = 4
) (
   input  wire logic             core_clk,
   input  wire logic             nrst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign in_ready  = count != (AW+1)'(DEPTH);
   assign out_valid = count != '0;
   assign out_data  = mem[rd_ptr];

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

// *** logic/eeprom_bus_port.sv ***
`include "eeprom_port_consts.svh"
`default_nettype none
// How it works
// - The port reaches a 128-byte EEPROM only over a data line and a clock line.
// - The data line follows bit 1 and the clock line bit 2 of the control register at 90h.
// - Bit 0 of the control register switches the EEPROM power.
// - A data change while the clock is high is a start or stop, never a data bit.
// - The data line is two-way, carrying data into and out of the memory.
// - The clock line is driven from the processor side and times every bit.
// - Writing one to the clock bit drives the clock high, zero drives it low.
// - Writing one to the data bit releases the line, zero drives it low.
// - Clearing the power bit powers the EEPROM down and floats all its pins.
// - While power is off the three bits read zero.
// - At reset the three bits are one and bits 7 to 3 read zero.
// - A start is the data line falling while the clock is high.
// - A stop is the data line rising while the clock is high.
// - The memory acknowledges each byte by holding data low on a ninth clock.
module eeprom_bus_port (
   input  wire logic       core_clk,
   input  wire logic       nrst,
   input  wire logic       link_clk,
   input  wire logic       link_nrst,
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_write,
   input  wire logic [7:0] reg_wdata,
   output logic [7:0]      reg_rdata,
   output logic            scl_out,
   output logic            scl_oe,
   output logic            sda_out,
   output logic            sda_oe,
   input  wire logic       sda_in,
   output logic            eeprom_power,
   output logic            bus_busy,
   output logic            start_seen,
   output logic            stop_seen
);
   // ----------------------------------------
   // Control register
   // ----------------------------------------
   logic       clock_bit;
   logic       data_bit;
   logic       power_bit;
   logic       sel;

   // Reset image of the three bits, split by position
   localparam logic [2:0] RESET_BITS = `BUS_CONTROL_RESET;

   assign sel = reg_addr == `BUS_CONTROL_ADDR;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         clock_bit <= RESET_BITS[`CLOCK_BIT_POS];
         data_bit  <= RESET_BITS[`DATA_BIT_POS];
         power_bit <= RESET_BITS[`POWER_BIT_POS];
      end else if (reg_write && sel) begin
         clock_bit <= reg_wdata[`CLOCK_BIT_POS];
         data_bit  <= reg_wdata[`DATA_BIT_POS];
         power_bit <= reg_wdata[`POWER_BIT_POS];
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 8'h0;
      end else if (!sel || !power_bit) begin
         reg_rdata <= 8'h0;
      end else begin
         reg_rdata <= {5'h0, clock_bit, data_bit, power_bit};
      end
   end

   // ----------------------------------------
   // Pin drivers
   // ----------------------------------------
   // Two-wire link only
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         scl_out      <= 1'b1;
         scl_oe       <= 1'b1;
         eeprom_power <= 1'b1;
      end else begin
         scl_out      <= clock_bit;
         scl_oe       <= power_bit;
         eeprom_power <= power_bit;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sda_out <= 1'b0;
         sda_oe  <= 1'b0;
      end else begin
         // Open drain, never drives high
         sda_out <= 1'b0;
         sda_oe  <= power_bit && !data_bit;
      end
   end

   // ----------------------------------------
   // Line monitor on link clock
   // ----------------------------------------
   // Link side samples the data wire and the driven clock value scl_out; a pull-up makes a released line high
   logic scl_m1;
   logic scl_m2;
   logic sda_m1;
   logic sda_m2;
   logic scl_prev;
   logic sda_prev;
   logic start_tgl;
   logic stop_tgl;
   logic sda_wire;
   logic scl_wire;

   // Ack level read off the wire
   assign sda_wire = sda_in;
   assign scl_wire = scl_out;

   always_ff @(posedge link_clk or negedge link_nrst) begin
      if (!link_nrst) begin
         scl_m1 <= 1'b1;
         scl_m2 <= 1'b1;
         sda_m1 <= 1'b1;
         sda_m2 <= 1'b1;
      end else begin
         scl_m1 <= scl_wire;
         scl_m2 <= scl_m1;
         sda_m1 <= sda_wire;
         sda_m2 <= sda_m1;
      end
   end

   always_ff @(posedge link_clk or negedge link_nrst) begin
      if (!link_nrst) begin
         scl_prev  <= 1'b1;
         sda_prev  <= 1'b1;
         start_tgl <= 1'b0;
         stop_tgl  <= 1'b0;
      end else begin
         scl_prev <= scl_m2;
         sda_prev <= sda_m2;
         if (scl_m2 && scl_prev && sda_prev && !sda_m2) begin
            start_tgl <= ~start_tgl;
         end
         if (scl_m2 && scl_prev && !sda_prev && sda_m2) begin
            stop_tgl <= ~stop_tgl;
         end
      end
   end

   // ----------------------------------------
   // Event crossing into core domain
   // ----------------------------------------
   logic [2:0] start_s;
   logic [2:0] stop_s;
   logic       ev_valid;
   logic [1:0] ev_data;
   logic       q_valid;
   logic [1:0] q_data;
   logic       q_ready;
   logic       q_room;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         start_s <= 3'h0;
         stop_s  <= 3'h0;
      end else begin
         start_s <= {start_s[1:0], start_tgl};
         stop_s  <= {stop_s[1:0], stop_tgl};
      end
   end

   // Events lost only if software floods edges faster than the queue drains
   assign ev_data  = {start_s[2] ^ start_s[1], stop_s[2] ^ stop_s[1]};
   assign ev_valid = |ev_data;
   // Queue drains every cycle, so it never fills
   assign q_ready  = 1'b1;

   event_fifo #(
      .WIDTH (2),
      .DEPTH (`FIFO_DEPTH)
   ) i_event_fifo (
      .core_clk  (core_clk),
      .nrst      (nrst),
      .in_valid  (ev_valid),
      .in_ready  (q_room),
      .in_data   (ev_data),
      .out_valid (q_valid),
      .out_ready (q_ready),
      .out_data  (q_data)
   );

   // ----------------------------------------
   // Bus state
   // ----------------------------------------
   eeprom_port_pkg::bus_state_type state;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state      <= eeprom_port_pkg::bus_idle;
         bus_busy   <= 1'b0;
         start_seen <= 1'b0;
         stop_seen  <= 1'b0;
      end else begin
         start_seen <= q_valid && q_data[1];
         stop_seen  <= q_valid && q_data[0];
         if (!power_bit) begin
            state    <= eeprom_port_pkg::bus_idle;
            bus_busy <= 1'b0;
         end else if (q_valid) begin
            unique case (state)
               eeprom_port_pkg::bus_idle: begin
                  if (q_data[1]) begin
                     state    <= eeprom_port_pkg::bus_busy;
                     bus_busy <= 1'b1;
                  end
               end
               eeprom_port_pkg::bus_busy: begin
                  if (q_data[0] && !q_data[1]) begin
                     state    <= eeprom_port_pkg::bus_idle;
                     bus_busy <= 1'b0;
                  end
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // Register and pin assertions
   // ----------------------------------------
   clock_follows_a: assert property (@(posedge core_clk) disable iff (!nrst)
      $past(reg_write && sel) |-> ##1 scl_out == $past(reg_wdata[`CLOCK_BIT_POS], 2))
      else $error("clock pin does not follow written bit");
   data_drive_a: assert property (@(posedge core_clk) disable iff (!nrst)
      reg_write && sel && !reg_wdata[`DATA_BIT_POS] && reg_wdata[`POWER_BIT_POS] |-> ##2 sda_oe && !sda_out)
      else $error("data line not driven low");
   data_release_a: assert property (@(posedge core_clk) disable iff (!nrst)
      reg_write && sel && reg_wdata[`DATA_BIT_POS] |-> ##2 !sda_oe)
      else $error("data line not released");
   power_off_float_a: assert property (@(posedge core_clk) disable iff (!nrst)
      reg_write && sel && !reg_wdata[`POWER_BIT_POS] |-> ##2 !scl_oe && !sda_oe && !eeprom_power)
      else $error("pins not floated when powered down");
   power_on_drive_a: assert property (@(posedge core_clk) disable iff (!nrst)
      reg_write && sel && reg_wdata[`POWER_BIT_POS] |-> ##2 scl_oe && eeprom_power)
      else $error("pins not driven when powered up");
   float_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
      !power_bit |=> !scl_oe && !sda_oe && !eeprom_power)
      else $error("pins driven while unpowered");
   read_zero_off_a: assert property (@(posedge core_clk) disable iff (!nrst)
      !power_bit |=> reg_rdata == 8'h0)
      else $error("read nonzero while unpowered");
   upper_zero_a: assert property (@(posedge core_clk) disable iff (!nrst)
      reg_rdata[7:3] == 5'h0)
      else $error("unimplemented bits nonzero");
   power_map_a: assert property (@(posedge core_clk) disable iff (!nrst)
      sel && power_bit |=> reg_rdata[`POWER_BIT_POS])
      else $error("power bit reads wrong");
   read_back_a: assert property (@(posedge core_clk) disable iff (!nrst)
      reg_write && sel && reg_wdata[`POWER_BIT_POS] ##1 sel && !reg_write
      |=> reg_rdata[2:0] == $past(reg_wdata[2:0], 2))
      else $error("read back differs from written bits");

   // ----------------------------------------
   // Bus state assertions
   // ----------------------------------------
   event_room_a: assert property (@(posedge core_clk) disable iff (!nrst)
      ev_valid |-> q_room)
      else $error("start or stop event dropped");
   busy_start_a: assert property (@(posedge core_clk) disable iff (!nrst)
      power_bit && q_valid && q_data == 2'b10 |=> bus_busy)
      else $error("start did not set busy");
   busy_stop_a: assert property (@(posedge core_clk) disable iff (!nrst)
      state == eeprom_port_pkg::bus_busy && q_valid && q_data == 2'b01 |=> !bus_busy)
      else $error("stop did not clear busy");
   busy_off_a: assert property (@(posedge core_clk) disable iff (!nrst)
      !power_bit |=> !bus_busy)
      else $error("bus busy while unpowered");

   // ----------------------------------------
   // Coverage
   // ----------------------------------------
   start_cov_c: cover property (@(posedge core_clk) disable iff (!nrst) start_seen);
   stop_cov_c: cover property (@(posedge core_clk) disable iff (!nrst) stop_seen);
   power_cov_c: cover property (@(posedge core_clk) disable iff (!nrst) $fell(eeprom_power));
   busy_cov_c: cover property (@(posedge core_clk) disable iff (!nrst) $fell(bus_busy));
endmodule
`default_nettype wire

// *** tb/eeprom_model.sv ***
`default_nettype none
module eeprom_model (
   input  wire logic scl,
   input  wire logic sda,
   input  wire logic powered,
   output logic      ack_pull
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------
   // Frame tracking
   // ----------------------------------------
   int   bit_count = 0;
   logic active    = 1'b0;
   initial ack_pull = 1'b0;
   always @(negedge sda) if (scl === 1'b1 && powered === 1'b1) begin
      active = 1'b1;
      bit_count = 0;
   end
   always @(posedge sda) if (scl === 1'b1) active = 1'b0;
   always @(posedge scl) if (active) bit_count++;
   always @(negedge scl) begin
      if (bit_count == 8) ack_pull = 1'b1;
      else if (bit_count == 9) begin
         // Released on the falling edge so the line returns to the pull-up
         ack_pull = 1'b0;
         bit_count = 0;
      end
   end
   always @(negedge powered) begin
      active = 1'b0;
      ack_pull = 1'b0;
   end
endmodule
`default_nettype wire

// *** tb/eeprom_bus_port_test.sv ***
`include "eeprom_port_consts.svh"
`default_nettype none
module eeprom_bus_port_test;
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic       core_clk  = 1'b0;
   logic       nrst      = 1'b0;
   logic       link_clk  = 1'b0;
   logic       link_nrst = 1'b0;
   logic [7:0] reg_addr  = 8'h00;
   logic       reg_write = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic       scl_out, scl_oe, sda_out, sda_oe, eeprom_power, bus_busy, start_seen, stop_seen;
   wire        ack_pull;
   wire        scl_line  = scl_oe & scl_out;
   // Pull-up holds the line high unless a party sinks it
   wire        sda_in    = ~((sda_oe & ~sda_out) | ack_pull);
   int         n_errors  = 0;
   int         num_checks = 0;
   int         n_start   = 0;
   int         n_stop    = 0;
   logic [7:0] v;

   always #25 core_clk = ~core_clk;
   initial begin
      #3;
      forever #7.5 link_clk = ~link_clk;
   end
   always @(negedge core_clk) begin
      if (start_seen === 1'b1) n_start++;
      if (stop_seen === 1'b1) n_stop++;
   end

   eeprom_bus_port i_eeprom_bus_port (
      .core_clk(core_clk), .nrst(nrst), .link_clk(link_clk), .link_nrst(link_nrst),
      .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe), .sda_in(sda_in),
      .eeprom_power(eeprom_power), .bus_busy(bus_busy), .start_seen(start_seen), .stop_seen(stop_seen)
   );
   eeprom_model i_eeprom_model (.scl(scl_line), .sda(sda_in), .powered(eeprom_power), .ack_pull(ack_pull));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Phases held long
   // Spaced by five cycles so the link side sees each phase
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_write = 1'b1;
      @(negedge core_clk);
      reg_write = 1'b0;
      repeat (3) @(negedge core_clk);
   endtask
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge core_clk);
      reg_addr = a;
      @(negedge core_clk);
      d = reg_rdata;
   endtask
   task automatic wait_events(input int s, input int p);
      for (int i = 0; i < 40 && !(n_start == s && n_stop == p); i++) @(negedge core_clk);
      check(8'(n_start), 8'(s));
      check(8'(n_stop), 8'(p));
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      #200000;
      n_errors++;
      summarize();
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (12) @(negedge core_clk);
      nrst = 1'b1;
      link_nrst = 1'b1;
      read_reg(`BUS_CONTROL_ADDR, v);
      check(v, 8'h07);
      check({4'h0, scl_out, scl_oe, eeprom_power, sda_oe}, 8'h0e);
      write_reg(`BUS_CONTROL_ADDR, 8'hfb);
      read_reg(`BUS_CONTROL_ADDR, v);
      check(v, 8'h03);
      check({6'h0, scl_out, sda_oe}, 8'h00);
      write_reg(8'h91, 8'h04);
      read_reg(8'h91, v);
      check(v, 8'h00);
      read_reg(`BUS_CONTROL_ADDR, v);
      check(v, 8'h03);
      // Start, nine clocks with the memory acknowledging, then stop
      // Software makes every edge but the memory's acknowledge
      write_reg(`BUS_CONTROL_ADDR, 8'h07);
      write_reg(`BUS_CONTROL_ADDR, 8'h05);
      wait_events(1, 0);
      check({7'h0, bus_busy}, 8'h01);
      check({6'h0, sda_oe, sda_out}, 8'h02);
      write_reg(`BUS_CONTROL_ADDR, 8'h01);
      for (int i = 0; i < 9; i++) begin
         write_reg(`BUS_CONTROL_ADDR, 8'h03);
         write_reg(`BUS_CONTROL_ADDR, 8'h07);
         check({7'h0, sda_in}, (i == 8) ? 8'h00 : 8'h01);
      end
      wait_events(1, 0);
      write_reg(`BUS_CONTROL_ADDR, 8'h01);
      write_reg(`BUS_CONTROL_ADDR, 8'h05);
      write_reg(`BUS_CONTROL_ADDR, 8'h07);
      wait_events(1, 1);
      check({7'h0, bus_busy}, 8'h00);
      // Power off hides the bits and floats the pins
      write_reg(`BUS_CONTROL_ADDR, 8'h06);
      read_reg(`BUS_CONTROL_ADDR, v);
      check(v, 8'h00);
      check({5'h0, scl_oe, sda_oe, eeprom_power}, 8'h00);
      write_reg(`BUS_CONTROL_ADDR, 8'h07);
      read_reg(`BUS_CONTROL_ADDR, v);
      check(v, 8'h07);
      check({7'h0, eeprom_power}, 8'h01);
      summarize();
   end
endmodule
`default_nettype wire
